// File: arbiter_defines.svh
`ifndef ARBITER_DEFINES_SVH
`define ARBITER_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses on the register bus).
`define ARB_CTRL_OFFSET 8'h00
`define ARB_STATUS_OFFSET 8'h04
`define ARB_ADDR_WIDTH 8

// ==========================================================================
// Control register field positions.
`define ARB_BW_ELEVATE_BIT 25
`define ARB_WIDE_COUNT_BIT 24
`define ARB_DMA_PRIO_MSB 21
`define ARB_DMA_PRIO_LSB 20
`define ARB_CORE_PRIO_MSB 19
`define ARB_CORE_PRIO_LSB 18
`define ARB_FIXED_BIT 14
`define ARB_TIMEOUT_BIT 13
`define ARB_PARK_BIT 12
`define ARB_LOCKOUT_MSB 11
`define ARB_LOCKOUT_LSB 8

// ==========================================================================
// Reset values and masks.
`define ARB_CTRL_RESET 32'h0038_0000
`define ARB_CTRL_WMASK 32'h033c_7f00
`define ARB_DMA_PRIO_DEFAULT 2'h3
`define ARB_CORE_PRIO_DEFAULT 2'h2

// ==========================================================================
// Bus answer codes.
`define ARB_RESP_OKAY 2'h0
`define ARB_RESP_SLVERR 2'h2

`endif

// File: arbiter_pkg.sv
// ==========================================================================
// Types shared by the arbiter files.
package arbiter_pkg;

  // Identity of a bus master port.
  typedef enum logic {
    CORE_MASTER = 1'b0,
    DMA_MASTER = 1'b1
  } master_type;

endpackage

// File: lockout_counter.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Counts denied cycles for one master and flags when the limit of
// two to the power of the exponent is reached. Saturates at the limit.
module lockout_counter #(
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control.
  input wire logic clear,
  input wire logic count_en,
  input wire logic [3:0] exponent,
  // Status.
  output logic reached
);

  // Denied-cycle count and its next value.
  logic [CNT_WIDTH-1:0] count;
  logic [CNT_WIDTH-1:0] next_count;
  // Limit derived from the exponent.
  logic [CNT_WIDTH-1:0] limit;

  // Next count: clear wins over counting, and counting stops at the limit.
  always_comb begin
    limit = {{(CNT_WIDTH-1){1'b0}}, 1'b1} << exponent;
    reached = (count >= limit);
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (count_en && !reached) begin
      next_count = count + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Register stage; reset empties the counter.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

`default_nettype wire

// File: internal_bus_master_arbiter.sv
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "arbiter_defines.svh"

module internal_bus_master_arbiter
  import arbiter_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address channel.
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response channel.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address channel.
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data channel.
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Requests from the two bus masters.
  input wire logic dma_req,
  input wire logic core_req,
  input wire logic dma_bw_request,
  // Bus address phase availability.
  input wire logic addr_phase_free,
  // Address phase grants.
  output logic dma_grant,
  output logic core_grant,
  // Arbiter state seen outside.
  output arbiter_pkg::master_type arb_pointer,
  output arbiter_pkg::master_type current_master,
  // Configuration passed to the DMA controller.
  output logic dma_wide_count_sel
);

  // ========================================================================
  // Declarations.

  // Control register and its next value.
  logic [31:0] arbiter_control_reg;
  logic [31:0] next_ctrl;
  // Arbitration pointer and last granted master.
  master_type pointer;
  master_type next_pointer;
  master_type cur_master;
  master_type next_cur_master;
  // Write channel holding registers.
  logic aw_held;
  logic next_aw_held;
  logic [`ARB_ADDR_WIDTH-1:0] aw_addr;
  logic [`ARB_ADDR_WIDTH-1:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  // Response registers.
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  // Control fields.
  logic fixed_mode;
  logic timeout_en;
  logic park_select;
  logic [3:0] lockout_exponent;
  logic dma_bw_elevate_en;
  logic [1:0] dma_master_priority;
  logic [1:0] core_master_priority;
  // Priorities after the uniqueness check.
  logic [1:0] dma_prio;
  logic [1:0] core_prio;
  logic [1:0] cur_prio;
  // Round-robin scores.
  logic [1:0] dma_score;
  logic [1:0] core_score;
  // Arbitration helpers.
  logic use_rr;
  logic dma_cand;
  logic core_cand;
  logic dma_elevated;
  logic dma_wins;
  master_type park_target;
  // Lockout flags from the counters.
  logic dma_locked;
  logic core_locked;
  logic lockout_active;
  logic count_enable;
  // Status word and byte-lane mask.
  logic [31:0] status_word;
  logic [31:0] lane_mask;

  // ========================================================================
  // Field extraction.

  // Split the control register into named fields.
  always_comb begin
    fixed_mode = arbiter_control_reg[`ARB_FIXED_BIT];
    timeout_en = arbiter_control_reg[`ARB_TIMEOUT_BIT];
    park_select = arbiter_control_reg[`ARB_PARK_BIT];
    lockout_exponent = arbiter_control_reg[`ARB_LOCKOUT_MSB:`ARB_LOCKOUT_LSB];
    dma_bw_elevate_en = arbiter_control_reg[`ARB_BW_ELEVATE_BIT];
    dma_master_priority = arbiter_control_reg[`ARB_DMA_PRIO_MSB:`ARB_DMA_PRIO_LSB];
    core_master_priority = arbiter_control_reg[`ARB_CORE_PRIO_MSB:`ARB_CORE_PRIO_LSB];
    dma_wide_count_sel = arbiter_control_reg[`ARB_WIDE_COUNT_BIT];
  end

  // ========================================================================
  // Grant and arbitration.

  // Only the pointed master can take the address phase this cycle, so at
  // most one grant exists and every other requester waits a cycle.
  always_comb begin
    dma_grant = addr_phase_free && (pointer == DMA_MASTER) && dma_req;
    core_grant = addr_phase_free && (pointer == CORE_MASTER) && core_req;
  end

  // Next pointer and current master. Software is trusted to program
  // unique priorities; equal ones fall back to the reset order so the
  // comparison below never needs a tie rule beyond DMA first.
  always_comb begin
    if (dma_master_priority == core_master_priority) begin
      dma_prio = `ARB_DMA_PRIO_DEFAULT;
      core_prio = `ARB_CORE_PRIO_DEFAULT;
    end else begin
      dma_prio = dma_master_priority;
      core_prio = core_master_priority;
    end
    // Lockout only matters in fixed mode, so round-robin hides it.
    lockout_active = fixed_mode && (dma_locked || core_locked);
    use_rr = !fixed_mode || lockout_active;
    cur_prio = (cur_master == DMA_MASTER) ? dma_prio : core_prio;
    // Two-bit sums wrap, which is the modulo over four priority levels.
    dma_score = use_rr ? (dma_prio + cur_prio) : dma_prio;
    core_score = use_rr ? (core_prio + cur_prio) : core_prio;
    // A master granted now is the bus owner and takes no part.
    dma_cand = dma_req && !dma_grant;
    core_cand = core_req && !core_grant;
    dma_elevated = dma_bw_elevate_en && dma_bw_request;
    dma_wins = dma_elevated || (dma_score >= core_score);
    park_target = (dma_prio > core_prio) ? DMA_MASTER : CORE_MASTER;
    if (!park_select) begin
      park_target = dma_grant ? DMA_MASTER : (core_grant ? CORE_MASTER : cur_master);
    end
    if (dma_cand && core_cand) begin
      next_pointer = dma_wins ? DMA_MASTER : CORE_MASTER;
    end else if (dma_cand) begin
      next_pointer = DMA_MASTER;
    end else if (core_cand) begin
      next_pointer = CORE_MASTER;
    end else begin
      next_pointer = park_target;
    end
    // The granted master becomes current; in round-robin its own priority
    // is then added to both scores, modulo four, for the next comparison.
    next_cur_master = cur_master;
    if (dma_grant) begin
      next_cur_master = DMA_MASTER;
    end else if (core_grant) begin
      next_cur_master = CORE_MASTER;
    end
  end

  // Register the pointer and current master.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pointer <= DMA_MASTER;
      cur_master <= DMA_MASTER;
    end else begin
      pointer <= next_pointer;
      cur_master <= next_cur_master;
    end
  end

  // Pointer state for observers.
  always_comb begin
    arb_pointer = pointer;
    current_master = cur_master;
  end

  // ========================================================================
  // Anti-lock-out counters.

  // Counting runs only in fixed mode with the timeout enabled.
  always_comb begin
    count_enable = fixed_mode && timeout_en;
  end

  // DMA master denial counter; a grant clears its lock.
  lockout_counter #(
    .CNT_WIDTH(CNT_WIDTH)
  ) dma_lockout (
    .clk(clk),
    .reset_n(reset_n),
    .clear(dma_grant || !count_enable),
    .count_en(dma_req && !dma_grant),
    .exponent(lockout_exponent),
    .reached(dma_locked)
  );

  // Core master denial counter; a grant clears its lock.
  lockout_counter #(
    .CNT_WIDTH(CNT_WIDTH)
  ) core_lockout (
    .clk(clk),
    .reset_n(reset_n),
    .clear(core_grant || !count_enable),
    .count_en(core_req && !core_grant),
    .exponent(lockout_exponent),
    .reached(core_locked)
  );

  // ========================================================================
  // Register bus slave.

  // Handshake readies: a channel is open while nothing is held for it
  // and no answer is waiting, which limits the slave to one write.
  always_comb begin
    awready = !aw_held && !bvalid;
    wready = !w_held && !bvalid;
    arready = !rvalid;
  end

  // Status word: pointer, current master and lockout state.
  always_comb begin
    status_word = {26'h0, !use_rr, core_locked, dma_locked, lockout_active, cur_master, pointer};
  end

  // Bus next-state logic: capture address and data in any order, write
  // once both are held, answer reads one cycle after the address.
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_ctrl = arbiter_control_reg;
    lane_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr[`ARB_ADDR_WIDTH-1:0];
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (aw_held && w_held) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (aw_addr == `ARB_CTRL_OFFSET) begin
        // Reserved bits stay zero; only enabled byte lanes change.
        next_ctrl = (arbiter_control_reg & ~(lane_mask & `ARB_CTRL_WMASK))
                  | (w_data & lane_mask & `ARB_CTRL_WMASK);
        next_bresp = `ARB_RESP_OKAY;
      end else if (aw_addr == `ARB_STATUS_OFFSET) begin
        next_bresp = `ARB_RESP_OKAY;
      end else begin
        next_bresp = `ARB_RESP_SLVERR;
      end
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      case (araddr[`ARB_ADDR_WIDTH-1:0])
        `ARB_CTRL_OFFSET: begin
          next_rdata = arbiter_control_reg;
          next_rresp = `ARB_RESP_OKAY;
        end
        `ARB_STATUS_OFFSET: begin
          next_rdata = status_word;
          next_rresp = `ARB_RESP_OKAY;
        end
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `ARB_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Bus and control registers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arbiter_control_reg <= `ARB_CTRL_RESET;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `ARB_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `ARB_RESP_OKAY;
    end else begin
      arbiter_control_reg <= next_ctrl;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

endmodule

`default_nettype wire

// File: internal_bus_master_arbiter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Port checks on the arbiter.
module internal_bus_master_arbiter_checker
  import arbiter_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register bus handshakes.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // Arbitration.
  input wire logic dma_req,
  input wire logic core_req,
  input wire logic addr_phase_free,
  input wire logic dma_grant,
  input wire logic core_grant,
  input wire master_type arb_pointer,
  input wire master_type current_master,
  input wire logic dma_wide_count_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A write taken with address and data going in at once; the slave also takes them in either order.
  sequence s_write_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_read_taken;
    arvalid && arready;
  endsequence
  a_single_grant: assert property (!(dma_grant && core_grant))
    else $error("two grants");
  a_dma_pointed: assert property (dma_grant == (addr_phase_free && dma_req && arb_pointer == DMA_MASTER))
    else $error("dma grant wrong");
  a_core_pointed: assert property (core_grant == (addr_phase_free && core_req && arb_pointer == CORE_MASTER))
    else $error("core grant wrong");
  a_grant_owner: assert property (core_grant |=> current_master == CORE_MASTER)
    else $error("owner not core");
  a_lone_core: assert property (core_req && !dma_req && !core_grant |=> arb_pointer == CORE_MASTER)
    else $error("pointer missed core");
  a_reset_state: assert property ($rose(reset_n) |-> arb_pointer == DMA_MASTER && !dma_wide_count_sel)
    else $error("bad reset state");
  a_write_answer: assert property (s_write_taken |-> ##2 bvalid)
    else $error("no write answer");
  a_read_answer: assert property (s_read_taken |=> rvalid)
    else $error("no read answer");
  a_resp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
endmodule

bind internal_bus_master_arbiter internal_bus_master_arbiter_checker #(.CNT_WIDTH(CNT_WIDTH)) u_checker (
  .clk, .reset_n, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
  .rvalid, .dma_req, .core_req, .addr_phase_free, .dma_grant, .core_grant, .arb_pointer, .current_master,
  .dma_wide_count_sel
);
`default_nettype wire

// File: master_pair_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================
// The two bus masters behind the arbiter.
module master_pair_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Wishes from the bench and grants back.
  input wire logic want_dma,
  input wire logic want_core,
  input wire logic dma_grant,
  input wire logic core_grant,
  // Requests.
  output logic dma_req,
  output logic core_req
);
  // A master keeps asking until it is served, so a denied request is never lost.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dma_req <= 1'h0;
      core_req <= 1'h0;
    end else begin
      dma_req <= want_dma || (dma_req && !dma_grant);
      core_req <= want_core || (core_req && !core_grant);
    end
  end
endmodule
`default_nettype wire

// File: internal_bus_master_arbiter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Self-checking bench with a cycle model of the pointer.
module internal_bus_master_arbiter_tb_top;
  import arbiter_pkg::*;
  logic clk = 1'h0, reset_n = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d, cfg;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, dma_req, core_req, dma_grant, core_grant, wide;
  logic [1:0] bresp, rresp, r, dp, cp;
  logic want_dma = 1'h0, want_core = 1'h0, bw = 1'h0, free = 1'h0;
  logic fixed_m, park_b, elev_b, g_d, g_c;
  master_type arb_pointer, current_master, exp_ptr, exp_cur, n;
  logic [15:0] seed = 16'h708f;
  int num_errors = 0, total_checks = 0;
  always #5 clk = ~clk;
  internal_bus_master_arbiter #(.CNT_WIDTH(16)) u_internal_bus_master_arbiter (
    .clk, .reset_n, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .dma_req, .core_req, .dma_bw_request(bw), .addr_phase_free(free), .dma_grant, .core_grant,
    .arb_pointer, .current_master, .dma_wide_count_sel(wide)
  );
  master_pair_model u_master_pair_model (
    .clk, .reset_n, .want_dma, .want_core, .dma_grant, .core_grant, .dma_req, .core_req
  );
  // ==============================
  // Compare and report.
  task check_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task check_word(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==============================
  // Register bus master; each wait is bounded.
  task axi_wr(input logic [31:0] a, input logic [31:0] v);
    int i;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
    if (i == 50) begin
      num_errors++;
      summarize;
    end
  endtask
  task axi_rd(input logic [31:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (i == 50) begin
      num_errors++;
      summarize;
    end
  endtask
  task do_reset;
    reset_n <= 1'h0;
    want_dma <= 1'h0;
    want_core <= 1'h0;
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
  endtask
  // ==============================
  // Expected next pointer from the mode, priorities and requests.
  function master_type nxt(input logic dq, cq, gd, gc);
    logic [1:0] pc, sd, sc;
    pc = (exp_cur == DMA_MASTER) ? dp : cp;
    sd = dp + pc;
    sc = cp + pc;
    if (dq && !gd && cq && !gc) begin
      if (elev_b && bw) return DMA_MASTER;
      if (fixed_m) return (dp > cp) ? DMA_MASTER : CORE_MASTER;
      return (sd >= sc) ? DMA_MASTER : CORE_MASTER;
    end
    if (dq && !gd) return DMA_MASTER;
    if (cq && !gc) return CORE_MASTER;
    if (park_b) return (dp > cp) ? DMA_MASTER : CORE_MASTER;
    if (gd || gc) return gd ? DMA_MASTER : CORE_MASTER;
    return exp_cur;
  endfunction
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // ==============================
  // Main sequence.
  initial begin
    do_reset;
    axi_rd(32'h0);
    check_word(d, 32'h0038_0000);
    check_word({30'h0, r}, 32'h0);
    check_bit(wide, 1'h0);
    axi_wr(32'h0, 32'hffff_ffff);
    check_bit(wide, 1'h1);
    check_word({30'h0, r}, 32'h0);
    axi_rd(32'h0);
    check_word(d, 32'h033c_7f00);
    axi_wr(32'h8, 32'h0);
    check_word({30'h0, r}, 32'h2);
    axi_rd(32'h8);
    check_word({28'h0, d[1:0], r}, 32'h2);
    $display("test registers done");
    // Fixed mode, core above DMA, denial limit of eight cycles.
    do_reset;
    axi_wr(32'h0, 32'h001c_6300);
    want_dma <= 1'h1;
    want_core <= 1'h1;
    repeat (5) @(posedge clk);
    #1 check_bit(arb_pointer, CORE_MASTER);
    // Counts reach eight at the ninth edge, so the pointer moves one edge later.
    repeat (4) @(posedge clk);
    #1 check_bit(arb_pointer, CORE_MASTER);
    @(posedge clk);
    #1 check_bit(arb_pointer, DMA_MASTER);
    @(posedge clk);
    axi_rd(32'h4);
    check_word(d, 32'h0000_001f);
    $display("test lockout done");
    repeat (6) begin
      do_reset;
      seed = lfsr(seed);
      dp = seed[1:0];
      cp = seed[3:2];
      fixed_m = seed[4];
      park_b = seed[5];
      elev_b = seed[6];
      // The timeout enable is set only in round-robin, where it must not matter; the exponent is set in both modes.
      cfg = {6'h0, elev_b, seed[7], 2'h0, dp, cp, 3'h0, fixed_m, seed[8] & !fixed_m, park_b, seed[12:9], 8'h0};
      axi_wr(32'h0, cfg);
      repeat (2) @(posedge clk);
      check_bit(wide, seed[7]);
      if (dp == cp) begin
        dp = 2'h3;
        cp = 2'h2;
      end
      exp_cur = DMA_MASTER;
      exp_ptr = (park_b && cp > dp) ? CORE_MASTER : DMA_MASTER;
      repeat (100) begin
        @(negedge clk);
        g_d = free && dma_req && exp_ptr == DMA_MASTER;
        g_c = free && core_req && exp_ptr == CORE_MASTER;
        check_bit(dma_grant, g_d);
        check_bit(core_grant, g_c);
        check_bit(arb_pointer, exp_ptr);
        check_bit(current_master, exp_cur);
        n = nxt(dma_req, core_req, g_d, g_c);
        if (g_d || g_c) exp_cur = g_d ? DMA_MASTER : CORE_MASTER;
        exp_ptr = n;
        @(posedge clk);
        seed = lfsr(seed);
        want_dma <= seed[0];
        want_core <= seed[1];
        free <= seed[2] | seed[3];
        bw <= seed[4];
      end
      // Let the last stimulus edge pass so reset never re-drives it at once.
      @(posedge clk);
      $display("test random done");
    end
    summarize;
  end
endmodule
`default_nettype wire
